// ---- vtfq_classifier.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Hybrid accepts everything but broadcast-filtered frames, tags untouched
// - Trunk forwarding filter drops unlisted VIDs
// - Forwarding filter enable, resets disabled
// - Forwarding list: 20 entries, 1..4094, add/remove
// - Enabled empty forwarding list drops all trunk data frames
// - Hub trunk relaying filter drops unlisted VIDs
// - Relaying filter enable, resets disabled
// - Relaying list: 20 entries, 1..4094, add/remove
// - Enabled empty relaying list drops relayed
// - Three strict-priority queues, High first
// - Tag priority above threshold goes Mid
// - ToS precedence above threshold goes Mid
// - Otherwise Ethernet frames go Low
// - Control and management frames go High
// - Frames from the wired side to sister units go High
// - Data priority only read back on data_prio_out, never tagged onto frames, never steers queue
// - Management priority, reset 4 or 0
// - Priority threshold Trunk/Hybrid only, reset 3
// - ToS threshold on IPv4 precedence, reset 3
// - Subscriber broadcast filter drops I/G frames from the wired side
// - Trunk forwards only tagged frames, plus control and management
module vtfq_classifier
    import vtfq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic hub_side_unit,
    input wire logic [1:0] link_type,
    input wire logic fwd_filter_en,
    input wire logic rly_filter_en,
    input wire logic bcast_filter_en,
    input wire logic cfg_we,
    input wire logic [2:0] cfg_sel,
    input wire logic [2:0] cfg_val,
    input wire logic list_op_valid,
    input wire logic list_op_rly,
    input wire logic list_op_remove,
    input wire logic [11:0] list_op_vid,
    output logic list_op_done,
    output logic list_op_err,
    output logic [4:0] fwd_count,
    output logic [4:0] rly_count,
    output logic [2:0] prio_thr_out,
    output logic [2:0] tos_thr_out,
    output logic [2:0] data_prio_out,
    output logic [2:0] mgmt_prio_out,
    input wire logic frm_valid,
    output logic frm_ready,
    input wire logic frm_from_wireless,
    input wire logic frm_to_wireless,
    input wire logic frm_tagged,
    input wire logic [11:0] frm_vid,
    input wire logic [2:0] frm_prio,
    input wire logic frm_is_ipv4,
    input wire logic [2:0] frm_tos_prec,
    input wire logic frm_ig_bit,
    input wire logic frm_is_mgmt,
    input wire logic frm_is_ctrl,
    input wire logic frm_to_sister,
    output logic drop_pulse,
    output logic q_valid,
    input wire logic q_ready,
    output logic [1:0] q_sel,
    output logic q_group,
    output logic [2:0] q_prio,
    output logic [11:0] q_vid
);
    localparam logic [2:0] SEL_PRIO_THR = 3'h0;
    localparam logic [2:0] SEL_TOS_THR = 3'h1;
    localparam logic [2:0] SEL_DATA_PRIO = 3'h2;
    localparam logic [2:0] SEL_MGMT_PRIO = 3'h3;

    logic [11:0] fwd_vid [VTFQ_LIST_DEPTH];
    logic [11:0] rly_vid [VTFQ_LIST_DEPTH];
    logic [VTFQ_LIST_DEPTH-1:0] fwd_used_reg;
    logic [VTFQ_LIST_DEPTH-1:0] rly_used_reg;
    logic [2:0] prio_thr_reg;
    logic [2:0] tos_thr_reg;
    logic [2:0] data_prio_reg;
    logic [2:0] mgmt_prio_reg;
    logic mgmt_init_reg;
    logic [VTFQ_LIST_DEPTH-1:0] fwd_hit;
    logic [VTFQ_LIST_DEPTH-1:0] rly_hit;
    logic [VTFQ_LIST_DEPTH-1:0] fwd_op_hit;
    logic [VTFQ_LIST_DEPTH-1:0] rly_op_hit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [VTFQ_DESC_W-1:0] fifo_out_data;
    logic [VTFQ_DESC_W-1:0] desc_next;
    logic accept_next;
    logic [1:0] queue_next;
    logic frm_take;

    function automatic logic [4:0] ones(input logic [VTFQ_LIST_DEPTH-1:0] v);
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < VTFQ_LIST_DEPTH; i++) begin
            n = n + 5'(v[i]);
        end
        return n;
    endfunction : ones

    function automatic logic [4:0] first_free(input logic [VTFQ_LIST_DEPTH-1:0] v);
        logic [4:0] idx;
        idx = '0;
        for (int i = VTFQ_LIST_DEPTH - 1; i >= 0; i--) begin
            if (!v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : first_free

    ////////////////////////////////////////////////////////////////////////////
    // Parallel compare of every list slot
    genvar g;
    generate
        for (g = 0; g < VTFQ_LIST_DEPTH; g++) begin : g_match
            assign fwd_hit[g] = fwd_used_reg[g] && (fwd_vid[g] == frm_vid);
            assign rly_hit[g] = rly_used_reg[g] && (rly_vid[g] == frm_vid);
            assign fwd_op_hit[g] = fwd_used_reg[g] && (fwd_vid[g] == list_op_vid);
            assign rly_op_hit[g] = rly_used_reg[g] && (rly_vid[g] == list_op_vid);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // List maintenance: one add or remove per operation
    logic op_in_range;
    logic [VTFQ_LIST_DEPTH-1:0] op_hit;
    logic [VTFQ_LIST_DEPTH-1:0] op_used;
    logic op_ok;
    assign op_in_range = (list_op_vid >= VTFQ_VID_MIN) && (list_op_vid <= VTFQ_VID_MAX);
    assign op_hit = list_op_rly ? rly_op_hit : fwd_op_hit;
    assign op_used = list_op_rly ? rly_used_reg : fwd_used_reg;
    // Duplicate adds are refused so one VID never owns two slots
    assign op_ok = list_op_remove ? (op_hit != '0)
                                  : (op_in_range && (op_hit == '0) && (op_used != '1));

    always_ff @(posedge clk) begin
        if (list_op_valid && op_ok && !list_op_remove) begin
            if (list_op_rly) begin
                rly_vid[first_free(rly_used_reg)] <= list_op_vid;
            end else begin
                fwd_vid[first_free(fwd_used_reg)] <= list_op_vid;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fwd_used_reg <= '0;
            rly_used_reg <= '0;
            list_op_done <= 1'b0;
            list_op_err <= 1'b0;
        end else begin
            list_op_done <= list_op_valid;
            list_op_err <= list_op_valid && !op_ok;
            if (list_op_valid && op_ok) begin
                if (list_op_rly && list_op_remove) begin
                    rly_used_reg <= rly_used_reg & ~rly_op_hit;
                end else if (list_op_rly) begin
                    rly_used_reg[first_free(rly_used_reg)] <= 1'b1;
                end else if (list_op_remove) begin
                    fwd_used_reg <= fwd_used_reg & ~fwd_op_hit;
                end else begin
                    fwd_used_reg[first_free(fwd_used_reg)] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fwd_count <= '0;
            rly_count <= '0;
        end else begin
            fwd_count <= ones(fwd_used_reg);
            rly_count <= ones(rly_used_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority settings
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_thr_reg <= VTFQ_PRIO_THR_RST;
            tos_thr_reg <= VTFQ_TOS_THR_RST;
            data_prio_reg <= VTFQ_DATA_PRIO_RST;
            mgmt_prio_reg <= VTFQ_MGMT_PRIO_HUB_RST;
            mgmt_init_reg <= 1'b1;
        end else begin
            mgmt_init_reg <= 1'b0;
            // Unit role is a strap, so the management default is caught after release
            if (mgmt_init_reg) begin
                mgmt_prio_reg <= hub_side_unit ? VTFQ_MGMT_PRIO_HUB_RST : VTFQ_MGMT_PRIO_SU_RST;
            end else if (cfg_we && cfg_sel == SEL_MGMT_PRIO) begin
                mgmt_prio_reg <= cfg_val;
            end
            if (cfg_we && cfg_sel == SEL_PRIO_THR) begin
                prio_thr_reg <= cfg_val;
            end
            if (cfg_we && cfg_sel == SEL_TOS_THR) begin
                tos_thr_reg <= cfg_val;
            end
            if (cfg_we && cfg_sel == SEL_DATA_PRIO) begin
                data_prio_reg <= cfg_val;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_thr_out <= VTFQ_PRIO_THR_RST;
            tos_thr_out <= VTFQ_TOS_THR_RST;
            data_prio_out <= VTFQ_DATA_PRIO_RST;
            mgmt_prio_out <= VTFQ_MGMT_PRIO_HUB_RST;
        end else begin
            prio_thr_out <= prio_thr_reg;
            tos_thr_out <= tos_thr_reg;
            data_prio_out <= data_prio_reg;
            mgmt_prio_out <= mgmt_prio_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accept / discard and queue choice, all combinational ahead of the FIFO
    always_comb begin
        logic is_data;
        logic trunk;
        logic relayed;
        logic use_tag;
        is_data = !frm_is_mgmt && !frm_is_ctrl;
        trunk = (link_type == VTFQ_LINK_TRUNK);
        relayed = frm_from_wireless && frm_to_wireless;
        use_tag = frm_tagged && (link_type != VTFQ_LINK_ACCESS);
        accept_next = 1'b1;
        if (is_data && trunk && !frm_tagged) begin
            accept_next = 1'b0;
        end
        // Empty list means no hit, so enabled filter drops every trunk data frame
        if (is_data && trunk && fwd_filter_en && (fwd_hit == '0)) begin
            accept_next = 1'b0;
        end
        if (is_data && trunk && hub_side_unit && rly_filter_en && relayed && (rly_hit == '0)) begin
            accept_next = 1'b0;
        end
        if (bcast_filter_en && !hub_side_unit && frm_ig_bit && !frm_from_wireless) begin
            accept_next = 1'b0;
        end
        if (frm_is_mgmt || frm_is_ctrl || (!frm_from_wireless && frm_to_sister)) begin
            queue_next = VTFQ_Q_HIGH;
        end else if (use_tag && (frm_prio > prio_thr_reg)) begin
            queue_next = VTFQ_Q_MID;
        end else if (frm_is_ipv4 && (frm_tos_prec > tos_thr_reg)) begin
            queue_next = VTFQ_Q_MID;
        end else begin
            queue_next = VTFQ_Q_LOW;
        end
        desc_next = {queue_next, frm_ig_bit, frm_prio, frm_vid};
    end

    assign frm_take = frm_valid && fifo_in_ready;
    assign frm_ready = fifo_in_ready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drop_pulse <= 1'b0;
        end else begin
            drop_pulse <= frm_take && !accept_next;
        end
    end

    vtfq_fifo #(
        .WIDTH(VTFQ_DESC_W),
        .DEPTH(VTFQ_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(frm_valid && accept_next),
        .in_ready(fifo_in_ready),
        .in_data(desc_next),
        .out_valid(fifo_out_valid),
        .out_ready(!q_valid || q_ready),
        .out_data(fifo_out_data)
    );

    // Output stage keeps every queue-side output on a flip-flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_valid <= 1'b0;
            q_sel <= '0;
            q_group <= 1'b0;
            q_prio <= '0;
            q_vid <= '0;
        end else if (!q_valid || q_ready) begin
            q_valid <= fifo_out_valid;
            {q_sel, q_group, q_prio, q_vid} <= fifo_out_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_fwd_filter_drop: assert property (@(posedge clk) disable iff (!nrst)
        frm_take && !frm_is_mgmt && !frm_is_ctrl && link_type == VTFQ_LINK_TRUNK
        && fwd_filter_en && fwd_hit == '0 |=> drop_pulse)
        else $error("unlisted trunk frame not dropped");
    a_high_queue: assert property (@(posedge clk) disable iff (!nrst)
        frm_valid && (frm_is_mgmt || frm_is_ctrl) |-> queue_next == VTFQ_Q_HIGH)
        else $error("management frame not high");
    a_tos_mid: assert property (@(posedge clk) disable iff (!nrst)
        frm_valid && !frm_is_mgmt && !frm_is_ctrl && !frm_to_sister && frm_is_ipv4
        && frm_tos_prec > tos_thr_reg |-> queue_next == VTFQ_Q_MID)
        else $error("precedence frame not mid");
    a_hybrid_pass: assert property (@(posedge clk) disable iff (!nrst)
        frm_take && link_type == VTFQ_LINK_HYBRID && !bcast_filter_en |=> !drop_pulse)
        else $error("hybrid frame dropped");
    a_list_bound: assert property (@(posedge clk) disable iff (!nrst)
        fwd_count <= 5'(VTFQ_LIST_DEPTH) && rly_count <= 5'(VTFQ_LIST_DEPTH))
        else $error("list overflow");
    a_bcast_drop: assert property (@(posedge clk) disable iff (!nrst)
        frm_take && bcast_filter_en && !hub_side_unit && frm_ig_bit && !frm_from_wireless |=> drop_pulse)
        else $error("group frame not blocked");
    a_rly_drop: assert property (@(posedge clk) disable iff (!nrst)
        frm_take && hub_side_unit && link_type == VTFQ_LINK_TRUNK && rly_filter_en
        && frm_from_wireless && frm_to_wireless && !frm_is_mgmt && !frm_is_ctrl
        && rly_hit == '0 |=> drop_pulse)
        else $error("unlisted relay not dropped");
    a_low_default: assert property (@(posedge clk) disable iff (!nrst)
        frm_valid && !frm_is_mgmt && !frm_is_ctrl && !frm_to_sister && !frm_is_ipv4
        && !frm_tagged |-> queue_next == VTFQ_Q_LOW)
        else $error("plain frame not low");
endmodule : vtfq_classifier
`default_nettype wire

// ---- vtfq_classifier_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module vtfq_classifier_tb_top
    import vtfq_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hub_side_unit = 1'b0;
    logic [1:0] link_type = 2'h0;
    logic fwd_filter_en = 1'b0, rly_filter_en = 1'b0, bcast_filter_en = 1'b0;
    logic cfg_we = 1'b0;
    logic [2:0] cfg_sel = 3'h0, cfg_val = 3'h0;
    logic list_op_valid = 1'b0, list_op_rly = 1'b0, list_op_remove = 1'b0;
    logic [11:0] list_op_vid = 12'h000;
    logic list_op_done, list_op_err, frm_ready, drop_pulse, q_valid, q_ready, q_group;
    logic [4:0] fwd_count, rly_count;
    logic [2:0] prio_thr_out, tos_thr_out, data_prio_out, mgmt_prio_out, q_prio;
    logic frm_valid = 1'b0, frm_from_wireless = 1'b0, frm_to_wireless = 1'b0, frm_tagged = 1'b0;
    logic [11:0] frm_vid = 12'h000;
    logic [11:0] q_vid;
    logic [2:0] frm_prio = 3'h0, frm_tos_prec = 3'h0;
    logic frm_is_ipv4 = 1'b0, frm_ig_bit = 1'b0, frm_is_mgmt = 1'b0, frm_is_ctrl = 1'b0, frm_to_sister = 1'b0;
    logic [1:0] q_sel;
    logic stall = 1'b0, slow = 1'b0;
    int miscompares = 0;
    int n_checks = 0;

    vtfq_classifier dut (.clk, .nrst, .hub_side_unit, .link_type, .fwd_filter_en, .rly_filter_en,
        .bcast_filter_en, .cfg_we, .cfg_sel, .cfg_val, .list_op_valid, .list_op_rly, .list_op_remove,
        .list_op_vid, .list_op_done, .list_op_err, .fwd_count, .rly_count, .prio_thr_out, .tos_thr_out,
        .data_prio_out, .mgmt_prio_out, .frm_valid, .frm_ready, .frm_from_wireless, .frm_to_wireless,
        .frm_tagged, .frm_vid, .frm_prio, .frm_is_ipv4, .frm_tos_prec, .frm_ig_bit, .frm_is_mgmt,
        .frm_is_ctrl, .frm_to_sister, .drop_pulse, .q_valid, .q_ready, .q_sel, .q_group, .q_prio, .q_vid);
    vtfq_wl_sink pm (.clk, .nrst, .stall, .slow, .q_valid, .q_ready, .q_sel, .q_group, .q_prio, .q_vid);

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset(input logic hub);
        @(posedge clk);
        nrst <= 1'b0;
        hub_side_unit <= hub;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset

    task automatic cfg(input logic [2:0] sel, input logic [2:0] val);
        logic [2:0] got [4];
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_sel <= sel;
        cfg_val <= val;
        @(posedge clk);
        cfg_we <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        got = '{prio_thr_out, tos_thr_out, data_prio_out, mgmt_prio_out};
        chk(got[sel[1:0]], val);
    endtask : cfg

    task automatic lop(input logic rly, input logic rm, input logic [11:0] vid, input logic e);
        @(posedge clk);
        list_op_valid <= 1'b1;
        list_op_rly <= rly;
        list_op_remove <= rm;
        list_op_vid <= vid;
        @(posedge clk);
        list_op_valid <= 1'b0;
        #1;
        chk({list_op_done, list_op_err}, {1'b1, e});
    endtask : lop

    // Ready is read just after an edge, where it is settled until the edge that takes the frame
    task automatic wait_ready();
        int i;
        for (i = 0; i < 300; i++) begin
            #1;
            if (frm_ready === 1'b1) break;
            @(posedge clk);
        end
        if (i == 300) begin
            miscompares++;
            test_done();
        end
    endtask : wait_ready

    task automatic set_f(input logic w, tw, tg, input logic [11:0] v, input logic [2:0] p, input logic ip,
            input logic [2:0] t, input logic ig, input logic [1:0] mg, input logic ss);
        frm_valid <= 1'b1;
        frm_from_wireless <= w;
        frm_to_wireless <= tw;
        frm_tagged <= tg;
        frm_vid <= v;
        frm_prio <= p;
        frm_is_ipv4 <= ip;
        frm_tos_prec <= t;
        frm_ig_bit <= ig;
        frm_is_ctrl <= mg[1];
        frm_is_mgmt <= mg[0];
        frm_to_sister <= ss;
    endtask : set_f

    task automatic frm(input logic w, tw, tg, input logic [11:0] v, input logic [2:0] p, input logic ip,
            input logic [2:0] t, input logic ig, input logic [1:0] mg, input logic ss, input logic ed,
            input logic [1:0] es);
        int n0;
        int i;
        logic dp;
        n0 = pm.log_q.size();
        dp = 1'b0;
        @(posedge clk);
        set_f(w, tw, tg, v, p, ip, t, ig, mg, ss);
        wait_ready();
        @(posedge clk);
        frm_valid <= 1'b0;
        // Drop flag stands only in the cycle after the taking edge, so look before waiting
        for (i = 0; i < 20; i++) begin
            #1;
            if (drop_pulse === 1'b1) dp = 1'b1;
            if (dp || pm.log_q.size() > n0) break;
            @(posedge clk);
        end
        chk(dp, ed);
        if (!ed) chk(pm.log_q.size() > n0 ? pm.log_q[n0] : 18'h3FFFF, {es, ig, p, v});
    endtask : frm

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        chk({prio_thr_out, tos_thr_out, data_prio_out}, {VTFQ_PRIO_THR_RST, VTFQ_TOS_THR_RST, VTFQ_DATA_PRIO_RST});
        chk(mgmt_prio_out, VTFQ_MGMT_PRIO_SU_RST);
        chk({fwd_count, rly_count}, 10'h000);
    endtask : t_reset_vals

    task automatic t_hybrid();
        frm(0, 1, 0, 12'h000, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(0, 1, 1, 12'h00A, 3'h4, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_MID);
        frm(0, 1, 1, 12'h00B, 3'h3, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(0, 1, 0, 12'h000, 3'h0, 1, 3'h4, 0, 2'h0, 0, 0, VTFQ_Q_MID);
        frm(0, 1, 1, 12'h00C, 3'h0, 1, 3'h3, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(0, 1, 1, 12'h00D, 3'h4, 1, 3'h7, 0, 2'h1, 0, 0, VTFQ_Q_HIGH);
        frm(0, 1, 1, 12'h00F, 3'h4, 0, 3'h0, 0, 2'h2, 0, 0, VTFQ_Q_HIGH);
        frm(0, 1, 1, 12'h00E, 3'h7, 1, 3'h7, 0, 2'h0, 1, 0, VTFQ_Q_HIGH);
        frm(0, 1, 0, 12'h000, 3'h0, 0, 3'h0, 1, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(1, 1, 1, 12'hFFE, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
    endtask : t_hybrid

    task automatic t_cfg();
        cfg(3'h0, 3'h7);
        frm(0, 1, 1, 12'h010, 3'h7, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        cfg(3'h0, 3'h0);
        frm(0, 1, 1, 12'h011, 3'h1, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_MID);
        cfg(3'h1, 3'h6);
        frm(0, 1, 0, 12'h000, 3'h0, 1, 3'h7, 0, 2'h0, 0, 0, VTFQ_Q_MID);
        frm(0, 1, 0, 12'h000, 3'h0, 1, 3'h6, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        cfg(3'h2, 3'h5);
        cfg(3'h3, 3'h2);
        cfg(3'h0, 3'h3);
        cfg(3'h1, 3'h3);
        cfg(3'h2, 3'h0);
        cfg(3'h3, 3'h4);
    endtask : t_cfg

    task automatic t_access_bcast();
        @(posedge clk);
        link_type <= VTFQ_LINK_ACCESS;
        frm(0, 1, 1, 12'h009, 3'h7, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(0, 1, 0, 12'h000, 3'h0, 1, 3'h5, 0, 2'h0, 0, 0, VTFQ_Q_MID);
        @(posedge clk);
        link_type <= VTFQ_LINK_HYBRID;
        bcast_filter_en <= 1'b1;
        frm(0, 1, 0, 12'h000, 3'h0, 0, 3'h0, 1, 2'h0, 0, 1, VTFQ_Q_LOW);
        frm(0, 1, 0, 12'h000, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        @(posedge clk);
        bcast_filter_en <= 1'b0;
    endtask : t_access_bcast

    // Stalled transmitter: the path must refuse once full, then drain in arrival order
    task automatic t_fifo();
        int k;
        int i;
        int n0;
        n0 = pm.log_q.size();
        @(posedge clk);
        stall <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 12; k++) begin
            @(posedge clk);
            set_f(0, 1, 1, 12'h100 + k[11:0], 3'h0, 0, 3'h0, 0, 2'h0, 0);
            #1;
            if (frm_ready !== 1'b1) break;
        end
        // Eight words in the FIFO plus one held by the stalled output stage
        chk(k, VTFQ_FIFO_DEPTH + 1);
        @(posedge clk);
        stall <= 1'b0;
        slow <= 1'b1;
        wait_ready();
        @(posedge clk);
        frm_valid <= 1'b0;
        for (i = 0; i < 200 && pm.log_q.size() < n0 + k + 1; i++) @(posedge clk);
        #1;
        for (i = 0; i <= k; i++) begin
            chk(pm.log_q.size() > n0 + i ? pm.log_q[n0 + i] : 18'h3FFFF, {VTFQ_Q_LOW, 4'h0, 12'h100 + i[11:0]});
        end
        @(posedge clk);
        slow <= 1'b0;
    endtask : t_fifo

    task automatic t_trunk();
        @(posedge clk);
        link_type <= VTFQ_LINK_TRUNK;
        frm(0, 1, 1, 12'h123, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(0, 1, 0, 12'h000, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        @(posedge clk);
        fwd_filter_en <= 1'b1;
        frm(0, 1, 1, 12'h005, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        lop(0, 0, 12'h005, 0);
        frm(0, 1, 1, 12'h005, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(0, 1, 1, 12'h006, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        frm(1, 0, 1, 12'h006, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        frm(0, 1, 1, 12'h006, 3'h4, 0, 3'h0, 0, 2'h1, 0, 0, VTFQ_Q_HIGH);
        @(posedge clk);
        fwd_filter_en <= 1'b0;
    endtask : t_trunk

    task automatic t_lists();
        int i;
        lop(0, 0, 12'h000, 1);
        lop(0, 0, VTFQ_VID_MAX + 12'h001, 1);
        lop(0, 1, 12'h002, 1);
        lop(0, 0, 12'h001, 0);
        lop(0, 0, 12'h001, 1);
        for (i = 2; i <= VTFQ_LIST_DEPTH; i++) lop(0, 0, i[11:0], 0);
        lop(0, 0, 12'h015, 1);
        @(posedge clk);
        #1;
        chk(fwd_count, 18'(VTFQ_LIST_DEPTH));
        lop(0, 1, 12'h014, 0);
        lop(0, 0, VTFQ_VID_MAX, 0);
        lop(1, 0, 12'h000, 1);
        lop(1, 0, VTFQ_VID_MAX, 0);
        lop(1, 1, 12'h005, 1);
        lop(1, 1, VTFQ_VID_MAX, 0);
        @(posedge clk);
        #1;
        chk({fwd_count, rly_count}, {5'(VTFQ_LIST_DEPTH), 5'h00});
    endtask : t_lists

    task automatic t_relay();
        chk(mgmt_prio_out, VTFQ_MGMT_PRIO_HUB_RST);
        @(posedge clk);
        link_type <= VTFQ_LINK_TRUNK;
        rly_filter_en <= 1'b1;
        frm(1, 1, 1, 12'h007, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        lop(1, 0, 12'h007, 0);
        frm(1, 1, 1, 12'h007, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        frm(1, 1, 1, 12'h008, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        frm(0, 1, 1, 12'h008, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
        @(posedge clk);
        fwd_filter_en <= 1'b1;
        frm(1, 1, 1, 12'h007, 3'h0, 0, 3'h0, 0, 2'h0, 0, 1, VTFQ_Q_LOW);
        lop(0, 0, 12'h007, 0);
        frm(1, 1, 1, 12'h007, 3'h0, 0, 3'h0, 0, 2'h0, 0, 0, VTFQ_Q_LOW);
    endtask : t_relay

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        t_reset_vals();
        t_hybrid();
        t_cfg();
        t_access_bcast();
        t_fifo();
        t_trunk();
        do_reset(1'b0);
        t_lists();
        do_reset(1'b1);
        t_relay();
        test_done();
    end
endmodule : vtfq_classifier_tb_top
`default_nettype wire

// ---- vtfq_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module vtfq_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule : vtfq_fifo
`default_nettype wire

// ---- vtfq_pkg.sv ----
package vtfq_pkg;
    localparam int VTFQ_LIST_DEPTH = 20;
    localparam int VTFQ_VID_W = 12;
    localparam logic [11:0] VTFQ_VID_MIN = 12'h001;
    localparam logic [11:0] VTFQ_VID_MAX = 12'hFFE;
    localparam logic [15:0] VTFQ_MGMT_NOVLAN = 16'hFFFF;
    localparam logic [2:0] VTFQ_PRIO_THR_RST = 3'h3;
    localparam logic [2:0] VTFQ_TOS_THR_RST = 3'h3;
    localparam logic [2:0] VTFQ_DATA_PRIO_RST = 3'h0;
    localparam logic [2:0] VTFQ_MGMT_PRIO_SU_RST = 3'h4;
    localparam logic [2:0] VTFQ_MGMT_PRIO_HUB_RST = 3'h0;
    localparam int VTFQ_FIFO_DEPTH = 8;
    // Descriptor: queue(2) group(1) prio(3) vid(12)
    localparam int VTFQ_DESC_W = 18;
    typedef enum logic [1:0] {VTFQ_Q_LOW, VTFQ_Q_MID, VTFQ_Q_HIGH} vtfq_queue_e;
    typedef enum logic [1:0] {VTFQ_LINK_HYBRID, VTFQ_LINK_TRUNK, VTFQ_LINK_ACCESS} vtfq_link_e;
endpackage : vtfq_pkg

// ---- vtfq_wl_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
module vtfq_wl_sink
    import vtfq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic slow,
    input wire logic q_valid,
    output logic q_ready,
    input wire logic [1:0] q_sel,
    input wire logic q_group,
    input wire logic [2:0] q_prio,
    input wire logic [11:0] q_vid
);
    logic [VTFQ_DESC_W-1:0] log_q[$];
    logic phase_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Slow mode takes only every other cycle, so the output stage must hold its word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 1'b0;
            q_ready <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
            q_ready <= ~stall & (~slow | phase_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Every word taken by the transmitter is logged with its queue label, in pop order
    always @(posedge clk) begin
        if (nrst && q_valid && q_ready) begin
            log_q.push_back({q_sel, q_group, q_prio, q_vid});
        end
    end
endmodule : vtfq_wl_sink
`default_nettype wire
